// file: pkg/qdac_defs.vh
`ifndef QDAC_DEFS_VH
`define QDAC_DEFS_VH
// Command word layout
`define QDAC_WORD_BITS     24
`define QDAC_RW_BIT        23
`define QDAC_REG_HI        21
`define QDAC_REG_LO        19
`define QDAC_ADDR_HI       18
`define QDAC_ADDR_LO       16
`define QDAC_DATA_HI       13
`define QDAC_DATA_LO       0
`define QDAC_CODE_BITS     14
// Register type selector codes
`define QDAC_REG_NOP       3'h0
`define QDAC_REG_DATA      3'h2
`define QDAC_REG_COARSE    3'h3
`define QDAC_REG_GAIN      3'h4
`define QDAC_REG_OFFSET    3'h5
`define QDAC_REG_CTRL      3'h1
// Channel address: 3'h4 addresses all four
`define QDAC_ADDR_ALL      3'h4
// Reset values
`define QDAC_DATA_RESET    14'h0000
`define QDAC_ADJ_RESET     14'h0000
// Serial clock ceiling and APB map
`define QDAC_SCLK_MAX_MHZ  30
`define QDAC_OFF_STATUS    12'h000
`define QDAC_OFF_CH0       12'h010
`define QDAC_OFF_GAIN0     12'h020
`define QDAC_OFF_OFFS0     12'h030
`define QDAC_OFF_SWITCH0   12'h040
`endif

// file: rtl/qdac_frontend.v
// The APB slave port and the placing of the registers were decided locally.
`include "qdac_defs.vh"
`default_nettype none
module qdac_frontend #(
  parameter CHANNELS = 4
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Serial link pins
  input  wire        sclk,
  input  wire        frame_n,
  input  wire        chain_data_in,
  output reg         chain_data_out,
  // Control pins
  input  wire        load_outputs_n,
  input  wire        async_clear_n,
  input  wire        coding_select_strap,
  // Analog-side controls, channel 0 shown on pins
  output reg  [14:0] segment_switch_controls,
  output reg  [11:0] ladder_switch_controls,
  output reg         output_clamp,
  output reg         offset_binary
);
  localparam CW = `QDAC_CODE_BITS;

  // Thermometer decode of the four top code bits
  function [14:0] therm;
    input [3:0] v;
    integer k;
    begin
      therm = 15'h0000;
      for (k = 0; k < 15; k = k + 1)
        if (k < v)
          therm[k] = 1'b1;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire sclk_s;
  wire frame_n_s;
  wire din_s;
  wire load_n_s;
  wire clr_n_s;
  wire strap_s;

  qdac_sync u_sclk  (.pclk(pclk), .presetn(presetn), .reset_level(1'b0), .din(sclk),                .dout(sclk_s));
  qdac_sync u_frame (.pclk(pclk), .presetn(presetn), .reset_level(1'b1), .din(frame_n),             .dout(frame_n_s));
  qdac_sync u_din   (.pclk(pclk), .presetn(presetn), .reset_level(1'b0), .din(chain_data_in),       .dout(din_s));
  qdac_sync u_load  (.pclk(pclk), .presetn(presetn), .reset_level(1'b0), .din(load_outputs_n),      .dout(load_n_s));
  qdac_sync u_clr   (.pclk(pclk), .presetn(presetn), .reset_level(1'b0), .din(async_clear_n),       .dout(clr_n_s));
  qdac_sync u_strap (.pclk(pclk), .presetn(presetn), .reset_level(1'b0), .din(coding_select_strap), .dout(strap_s));

  // Edge history; synchronisers reset to low, so the first few cycles are masked
  reg       sclk_d;
  reg       frame_d;
  reg       load_d;
  reg       clr_d;
  reg [2:0] settle;
  wire      live      = (settle == 3'h7);
  wire      sclk_fall = live & sclk_d & ~sclk_s;
  wire      sclk_rise = live & ~sclk_d & sclk_s;
  wire      frame_go  = live & frame_d & ~frame_n_s;
  wire      frame_end = live & ~frame_d & frame_n_s;
  wire      load_fall = live & load_d & ~load_n_s;
  wire      clr_fall  = live & clr_d & ~clr_n_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d  <= 1'b0;
      frame_d <= 1'b1;
      load_d  <= 1'b1;
      clr_d   <= 1'b1;
      settle  <= 3'h0;
    end else begin
      sclk_d  <= sclk_s;
      frame_d <= frame_n_s;
      load_d  <= load_n_s;
      clr_d   <= clr_n_s;
      if (!live)
        settle <= settle + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial shift register and frame counter
  reg [23:0] shreg;
  reg [5:0]  fall_cnt;
  reg        in_frame;
  reg        load_hi_seen;
  reg [CW-1:0] rb_word;

  // Count saturates so very long frames stay void
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg          <= 24'h000000;
      fall_cnt       <= 6'h00;
      in_frame       <= 1'b0;
      load_hi_seen   <= 1'b0;
      chain_data_out <= 1'b0;
    end else begin
      if (frame_go) begin
        in_frame     <= 1'b1;
        fall_cnt     <= 6'h00;
        load_hi_seen <= load_n_s;
      end else if (frame_end) begin
        in_frame <= 1'b0;
      end
      if (in_frame && sclk_fall) begin
        shreg <= {shreg[22:0], din_s};
        if (fall_cnt != 6'h3f)
          fall_cnt <= fall_cnt + 6'h01;
      end
      if (in_frame && load_n_s)
        load_hi_seen <= 1'b1;
      // Output changes on rising edges so it holds steady at falling ones
      if (in_frame && sclk_rise)
        chain_data_out <= shreg[23];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode of the captured word
  wire          w_read = shreg[`QDAC_RW_BIT];
  wire [2:0]    w_reg  = shreg[`QDAC_REG_HI:`QDAC_REG_LO];
  wire [2:0]    w_addr = shreg[`QDAC_ADDR_HI:`QDAC_ADDR_LO];
  wire [CW-1:0] w_data = shreg[`QDAC_DATA_HI:`QDAC_DATA_LO];
  // Bits 22, 15 and 14 are never looked at
  wire          w_ok   = frame_end & in_frame & (fall_cnt == 6'd24);

  //////////////////////////////////////////////////////////////////////////////
  // Channel registers
  reg [CW-1:0] input_reg [0:CHANNELS-1];
  reg [CW-1:0] dac_reg   [0:CHANNELS-1];
  reg [CW-1:0] gain_reg  [0:CHANNELS-1];
  reg [CW-1:0] offs_reg  [0:CHANNELS-1];
  reg          pending;
  reg          updated;
  integer      i;

  // Readback word chosen by the previous read command
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
      updated <= 1'b0;
      rb_word <= {CW{1'b0}};
      for (i = 0; i < CHANNELS; i = i + 1) begin
        input_reg[i] <= `QDAC_DATA_RESET;
        dac_reg[i]   <= `QDAC_DATA_RESET;
        gain_reg[i]  <= `QDAC_ADJ_RESET;
        offs_reg[i]  <= `QDAC_ADJ_RESET;
      end
    end else begin
      if (!clr_n_s && clr_fall) begin
        // Clear to zero code, wins over a same-cycle load
        for (i = 0; i < CHANNELS; i = i + 1) begin
          input_reg[i] <= `QDAC_DATA_RESET;
          dac_reg[i]   <= `QDAC_DATA_RESET;
        end
        updated <= 1'b1;
        pending <= 1'b0;
      end else begin
        if (w_ok && !w_read) begin
          for (i = 0; i < CHANNELS; i = i + 1) begin
            if (w_addr == i[2:0] || w_addr == `QDAC_ADDR_ALL) begin
              if (w_reg == `QDAC_REG_DATA) begin
                input_reg[i] <= w_data;
                if (!load_hi_seen) begin
                  dac_reg[i] <= w_data;
                  updated    <= 1'b1;
                end
              end
              if (w_reg == `QDAC_REG_GAIN)
                gain_reg[i] <= w_data;
              if (w_reg == `QDAC_REG_OFFSET)
                offs_reg[i] <= w_data;
            end
          end
          if (w_reg == `QDAC_REG_DATA && load_hi_seen)
            pending <= 1'b1;
        end
        // Load falling edge outside a frame copies all input registers out
        if (load_fall && !in_frame) begin
          for (i = 0; i < CHANNELS; i = i + 1)
            dac_reg[i] <= input_reg[i];
          updated <= 1'b1;
          pending <= 1'b0;
        end
      end
      if (w_ok && w_read) begin
        case (w_reg)
          `QDAC_REG_DATA:   rb_word <= input_reg[w_addr[1:0]];
          `QDAC_REG_GAIN:   rb_word <= gain_reg[w_addr[1:0]];
          `QDAC_REG_OFFSET: rb_word <= offs_reg[w_addr[1:0]];
          default:          rb_word <= {CW{1'b0}};
        endcase
      end
    end
  end

  // Readback lands in bits 15:2 of the APB status word, never in the shift register
  // Limitation: readback goes through the APB status word, not the serial pin

  //////////////////////////////////////////////////////////////////////////////
  // Switch decode and analog-side controls
  reg [1:0] sel_ch;
  wire [CW-1:0] code0 = dac_reg[0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segment_switch_controls <= 15'h0000;
      ladder_switch_controls  <= 12'h000;
      output_clamp            <= 1'b1;
      offset_binary           <= 1'b0;
    end else begin
      segment_switch_controls <= therm(code0[13:10]);
      ladder_switch_controls  <= code0[11:0];
      output_clamp            <= ~updated;
      offset_binary           <= strap_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  wire       acc   = psel & penable;
  wire [1:0] ch    = paddr[3:2];
  wire       valid = (paddr[11:4] <= 8'h04) && (paddr[11:4] == 8'h00 ? ch == 2'h0 : 1'b1);

  function [14:0] switch_word;
    input [CW-1:0] c;
    begin
      switch_word = therm(c[13:10]);
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      sel_ch  <= 2'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (~valid | pwrite);
      sel_ch  <= ch;
      if (psel && !penable) begin
        case ({paddr[11:4], 4'h0})
          `QDAC_OFF_STATUS:  prdata <= {16'h0000, rb_word[13:0], pending, ~updated} & 32'h3fffffff;
          `QDAC_OFF_CH0:     prdata <= {18'h00000, dac_reg[ch]};
          `QDAC_OFF_GAIN0:   prdata <= {18'h00000, gain_reg[ch]};
          `QDAC_OFF_OFFS0:   prdata <= {18'h00000, offs_reg[ch]};
          `QDAC_OFF_SWITCH0: prdata <= {5'h00, dac_reg[ch][11:0], switch_word(dac_reg[ch])};
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // qdac_frontend
`default_nettype wire

// file: rtl/qdac_sync.v
`default_nettype none
// Three-stage synchroniser with agreement filter on stages two and three
module qdac_sync (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  input  wire reset_level,
  // Async input and filtered level
  input  wire din,
  output reg  dout
);
  reg s1;
  reg s2;
  reg s3;

  // Stage one feeds only stage two
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        dout <= s2;
    end
  end
endmodule // qdac_sync
`default_nettype wire

// file: tb/qdac_chk.sv
`default_nettype none
module qdac_chk #(
  parameter CHANNELS = 4
) (
  // Clock, reset and bus handshake
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        frame_n,
  input wire logic        chain_data_out,
  input wire logic        coding_select_strap,
  input wire logic [14:0] segment_switch_controls,
  input wire logic        output_clamp,
  input wire logic        offset_binary
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] up;
  // Cycles since reset, so the strap check skips the filter's settling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up <= 4'h0;
    else if (up != 4'hf) up <= up + 4'h1;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence strap_steady_s;
    ((up == 4'hf) && $stable(coding_select_strap)) [*8];
  endsequence
  //////////////////////////////////////////////////
  chk_ready_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_write_refused: assert property (pready && pwrite |-> pslverr)
    else $error("write not refused");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_strap_follow: assert property (strap_steady_s |-> offset_binary == coding_select_strap)
    else $error("coding does not follow strap");
  chk_thermo_shape: assert property ((segment_switch_controls & (segment_switch_controls + 15'h1)) == 15'h0)
    else $error("segments not a thermometer");
  chk_clamp_sticky: assert property (!output_clamp |=> !output_clamp)
    else $error("clamp came back");
  chk_clamp_release: assert property ($changed(segment_switch_controls) |-> ##[0:1] !output_clamp)
    else $error("switches moved under clamp");
  chk_out_quiet: assert property (frame_n [*6] |-> $stable(chain_data_out))
    else $error("serial out moved outside frame");
endmodule // qdac_chk
bind qdac_frontend qdac_chk #(.CHANNELS(CHANNELS)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .pslverr, .frame_n, .chain_data_out, .coding_select_strap, .segment_switch_controls, .output_clamp, .offset_binary);
`default_nettype wire

// file: tb/qdac_host.sv
`default_nettype none
module qdac_host (
  // Clock and link pins
  input wire logic pclk,
  input wire logic chain_data_out,
  output var logic sclk,
  output var logic frame_n,
  output var logic chain_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] echo;
  // Link idles with clock high and frame off
  initial begin
    sclk = 1'b1;
    frame_n = 1'b1;
    chain_data_in = 1'b0;
    echo = 24'h0;
  end
  //////////////////////////////////////////////////
  // Frame of n falling edges; filler after the word is the inverse of its last bit
  task automatic send(input logic [47:0] w, input int n);
    logic [47:0] s;
    s = (w << (48 - n)) | ({48{~w[0]}} >> n);
    frame_n <= 1'b0;
    chain_data_in <= s[47];
    repeat (4) @(posedge pclk);
    repeat (n) begin
      sclk <= 1'b0;
      repeat (4) @(posedge pclk);
      echo <= {echo[22:0], chain_data_out};
      s = s << 1;
      sclk <= 1'b1;
      chain_data_in <= s[47];
      repeat (4) @(posedge pclk);
    end
    frame_n <= 1'b1;
    repeat (16) @(posedge pclk);
  endtask
endmodule // qdac_host
`default_nettype wire

// file: tb/quad_dac_serial_input_frontend_tb.sv
`include "qdac_defs.vh"
`default_nettype none
module quad_dac_serial_input_frontend_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        sclk, frame_n, chain_data_in, chain_data_out, load_outputs_n, async_clear_n;
  logic        coding_select_strap, output_clamp, offset_binary;
  logic [11:0] paddr, lad;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] seg;
  int          miscompares = 0;
  int          n_checks = 0;
  qdac_frontend #(.CHANNELS(4)) i_qdac_frontend (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sclk, .frame_n, .chain_data_in, .chain_data_out, .load_outputs_n,
    .async_clear_n, .coding_select_strap, .segment_switch_controls(seg), .ladder_switch_controls(lad),
    .output_clamp, .offset_binary);
  qdac_host i_qdac_host (.pclk, .chain_data_out, .sclk, .frame_n, .chain_data_in);
  //////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Setup, then access held until ready is seen
  task automatic apb(input logic wr, input logic [11:0] a);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    // Look mid-cycle so the closing edge is not raced; answer stands until that edge
    do @(negedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a);
    cmp(nm, exp, rd & m);
  endtask
  function automatic logic [47:0] wd(input logic [2:0] r, input logic [2:0] a, input logic [13:0] d);
    return {24'h0, 2'b01, r, a, 2'b11, d}; // spare bits set on purpose
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, well past the expected length of the run
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
  //////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, coding_select_strap} = '0;
    pwdata = 32'h5555_aaaa;
    load_outputs_n = 1'b1;
    async_clear_n = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    rdchk("clamp", `QDAC_OFF_STATUS, 32'h1, 32'h1);
    for (int c = 0; c < 4; c++) begin
      rdchk("dac", `QDAC_OFF_CH0 + 12'(4 * c), '1, 32'h0);
    end
    cmp("switches", 32'h0, {5'h0, lad, seg});
    apb(1'b1, `QDAC_OFF_CH0);
    cmp("write err", 32'h1, {31'h0, e});
    apb(1'b0, 12'hffc);
    cmp("unmapped err", 32'h1, {31'h0, e});
    $display("test reset done");
    i_qdac_host.send(wd(`QDAC_REG_DATA, 3'h1, 14'h1234), 24);
    rdchk("held", `QDAC_OFF_CH0 + 12'h4, '1, 32'h0);
    cmp("clamp pin", 32'h1, {31'h0, output_clamp});
    load_outputs_n <= 1'b0;
    repeat (10) @(posedge pclk);
    rdchk("loaded", `QDAC_OFF_CH0 + 12'h4, '1, 32'h1234);
    cmp("clamp pin", 32'h0, {31'h0, output_clamp});
    $display("test load done");
    for (int n = 0; n < 16; n++) begin
      i_qdac_host.send(wd(`QDAC_REG_DATA, 3'h0, {n[3:0], 10'h155}), 24);
      rdchk("dac0", `QDAC_OFF_CH0, '1, {18'h0, n[3:0], 10'h155});
      cmp("segments", {17'h0, (15'h1 << n) - 15'h1}, {17'h0, seg});
      cmp("ladder", {20'h0, n[1:0], 10'h155}, {20'h0, lad});
    end
    $display("test decode done");
    i_qdac_host.send(wd(`QDAC_REG_DATA, 3'h0, 14'h0aaa), 23);
    i_qdac_host.send(wd(`QDAC_REG_DATA, 3'h0, 14'h0aaa), 25);
    rdchk("void", `QDAC_OFF_CH0, '1, 32'h3d55);
    i_qdac_host.send({24'h5a3c96, 24'hc3a5f0}, 48);
    cmp("chain", 32'h5a3c96, {8'h0, i_qdac_host.echo});
    $display("test frames done");
    i_qdac_host.send(wd(`QDAC_REG_GAIN, `QDAC_ADDR_ALL, 14'h0aaa), 24);
    i_qdac_host.send(wd(`QDAC_REG_OFFSET, 3'h2, 14'h1555), 24);
    for (int c = 0; c < 4; c++) begin
      rdchk("gain", `QDAC_OFF_GAIN0 + 12'(4 * c), '1, 32'h0aaa);
      rdchk("offset", `QDAC_OFF_OFFS0 + 12'(4 * c), '1, c == 2 ? 32'h1555 : 32'h0);
    end
    i_qdac_host.send(wd(`QDAC_REG_DATA, 3'h0, 14'h0) | 48'h80_0000, 24);
    rdchk("readback", `QDAC_OFF_STATUS, 32'hfffc, 32'h3d55 << 2);
    $display("test adjust done");
    async_clear_n <= 1'b0;
    repeat (10) @(posedge pclk);
    async_clear_n <= 1'b1;
    rdchk("cleared", `QDAC_OFF_CH0, '1, 32'h0);
    cmp("segments", 32'h0, {17'h0, seg});
    coding_select_strap <= 1'b1;
    repeat (20) @(posedge pclk);
    cmp("offset binary", 32'h1, {31'h0, offset_binary});
    coding_select_strap <= 1'b0;
    repeat (20) @(posedge pclk);
    cmp("twos comp", 32'h0, {31'h0, offset_binary});
    $display("test clear and strap done");
    end_of_test();
  end
endmodule // quad_dac_serial_input_frontend_tb
`default_nettype wire
